// ### hdl/voice_pkg.sv
// Constants shared by the voice engine files
package voice_pkg;
  localparam int N_CHAN = 8;
  localparam int CYCLES_PER_SAMPLE = 384;
  localparam int SLOTS_PER_CHAN = CYCLES_PER_SAMPLE / N_CHAN;
  localparam int FRAC_BITS = 11;
  localparam int PTR_W = 16 + FRAC_BITS;
  // Per-channel parameter offsets within a channel bank
  localparam logic [2:0] OFS_AMPLITUDE = 3'h0;
  localparam logic [2:0] OFS_BALANCE = 3'h1;
  localparam logic [2:0] OFS_PITCH_LO = 3'h2;
  localparam logic [2:0] OFS_PITCH_HI = 3'h3;
  localparam logic [2:0] OFS_LOOP_LO = 3'h4;
  localparam logic [2:0] OFS_LOOP_HI = 3'h5;
  localparam logic [2:0] OFS_BEGIN = 3'h6;
  // Slot schedule inside one channel's 48 cycles
  localparam logic [5:0] SLOT_PARAM_LAST = 6'h07;
  localparam logic [5:0] SLOT_FETCH = 6'h08;
  localparam logic [5:0] SLOT_SAMPLE = 6'h14;
  localparam logic [5:0] SLOT_RESAMPLE = 6'h20;
  localparam logic [5:0] SLOT_MIX = 6'h21;
  localparam logic [5:0] SLOT_ACCUM = 6'h22;
  localparam logic [5:0] SLOT_LAST = 6'h2f;
  localparam logic [8:0] CNT_LAST = 9'h17f;
  localparam logic [7:0] LOOP_MARK = 8'hff;
  localparam logic [7:0] WAVE_CENTER = 8'h80;
  localparam logic [15:0] OUT_MAX = 16'hffff;
  localparam logic [15:0] OUT_MIN = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h8000;
  localparam int MIX_SHIFT = 3;
  typedef enum logic [1:0] {
    PH_PARAM = 2'b00,
    PH_FETCH = 2'b01,
    PH_REFETCH = 2'b11,
    PH_MIX = 2'b10
  } phase_t;
endpackage : voice_pkg

// ### hdl/param_if.sv
// Carrier between the sequencer and the parameter store
`timescale 1ns/1ps
`default_nettype none
interface param_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : param_if
`default_nettype wire

// ### hdl/param_store.sv
// Per-channel parameter memory, 8 banks of 8 bytes, registered read
`timescale 1ns/1ps
`default_nettype none
module param_store (
  input wire logic sys_clk_i,
  param_if.mem bus
);
  logic [7:0] mem_r [64];
  logic [7:0] rd_data_r;

  always_ff @(posedge sys_clk_i) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    rd_data_r <= mem_r[bus.rd_addr];
  end

  assign bus.rd_data = rd_data_r;
endmodule : param_store
`default_nettype wire

// ### hdl/voice_engine.sv
// Eight-channel PCM voice engine: pointer, fetch, gain mix and clamp
`timescale 1ns/1ps
`default_nettype none
module voice_engine (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sound_run_i,
  input wire logic [7:0] channel_on_i,
  input wire logic param_wr_i,
  input wire logic [2:0] param_chan_i,
  input wire logic [2:0] param_sel_i,
  input wire logic [7:0] param_data_i,
  output logic [15:0] wave_addr_o,
  output logic wave_rd_o,
  input wire logic [7:0] wave_data_i,
  output logic [15:0] left_sample_o,
  output logic [15:0] right_sample_o,
  output logic left_hold_pulse_o,
  output logic right_hold_pulse_o
);
  localparam int PW = voice_pkg::PTR_W;

  param_if pbus ();

  param_store u_store (
    .sys_clk_i(sys_clk_i),
    .bus(pbus.mem)
  );

  logic [8:0] cnt_r;
  logic [5:0] slot_r;
  logic [2:0] chan_r;
  voice_pkg::phase_t phase_r;
  logic [7:0] amplitude_level_r, lr_balance_gain_r, pitch_lo_r, pitch_hi_r;
  logic [7:0] loop_origin_low_r, loop_origin_high_r, begin_address_r;
  logic [PW-1:0] ptr_r [voice_pkg::N_CHAN];
  logic [7:0] was_on_r;
  logic [7:0] wave_s1_r, wave_s2_r, wave_s3_r, wave_q_r;
  logic [7:0] byte_r;
  logic byte_ok_r;
  logic signed [20:0] left_part_r, right_part_r;
  logic signed [15:0] acc_l_r, acc_r_r;
  logic [15:0] wave_addr_r;
  logic wave_rd_r;
  logic hold_r;
  logic [8:0] since_hold_r;
  logic sounding;
  logic [15:0] pitch_inc;

  // Saturating add of a contribution into a signed 16-bit sum
  function automatic logic signed [15:0] sat_add(input logic signed [15:0] a, input logic signed [20:0] b);
    logic signed [21:0] s;
    s = 22'(a) + 22'(b);
    if (s > 22'sd32767) begin
      sat_add = 16'sh7fff;
    end else if (s < -22'sd32768) begin
      sat_add = -16'sh8000;
    end else begin
      sat_add = s[15:0];
    end
  endfunction : sat_add

  assign sounding = sound_run_i & channel_on_i[chan_r];
  assign pitch_inc = {pitch_hi_r, pitch_lo_r};

  // Sample period counter: 384 cycles, 48 per channel, channel 0 first
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 9'h000;
      slot_r <= 6'h00;
      chan_r <= 3'h0;
    end else if (cnt_r == voice_pkg::CNT_LAST) begin
      cnt_r <= 9'h000;
      slot_r <= 6'h00;
      chan_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 9'h001;
      if (slot_r == voice_pkg::SLOT_LAST) begin
        slot_r <= 6'h00;
        chan_r <= chan_r + 3'h1;
      end else begin
        slot_r <= slot_r + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_r <= voice_pkg::PH_PARAM;
    end else begin
      case (phase_r)
        voice_pkg::PH_PARAM: if (slot_r == voice_pkg::SLOT_PARAM_LAST) phase_r <= voice_pkg::PH_FETCH;
        voice_pkg::PH_FETCH: if (slot_r == voice_pkg::SLOT_SAMPLE) phase_r <= voice_pkg::PH_REFETCH;
        voice_pkg::PH_REFETCH: if (slot_r == voice_pkg::SLOT_RESAMPLE) phase_r <= voice_pkg::PH_MIX;
        voice_pkg::PH_MIX: if (slot_r == voice_pkg::SLOT_LAST) phase_r <= voice_pkg::PH_PARAM;
        default: phase_r <= voice_pkg::PH_PARAM;
      endcase
    end
  end

  // Parameter store access: writes from the ports, reads by the schedule
  assign pbus.wr_en = param_wr_i;
  assign pbus.wr_addr = {param_chan_i, param_sel_i};
  assign pbus.wr_data = param_data_i;
  assign pbus.rd_addr = {chan_r, slot_r[2:0]};

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      amplitude_level_r <= 8'h00;
      lr_balance_gain_r <= 8'h00;
      pitch_lo_r <= 8'h00;
      pitch_hi_r <= 8'h00;
      loop_origin_low_r <= 8'h00;
      loop_origin_high_r <= 8'h00;
      begin_address_r <= 8'h00;
    end else if (phase_r == voice_pkg::PH_PARAM && slot_r != 6'h00) begin
      case (slot_r[2:0] - 3'h1)
        voice_pkg::OFS_AMPLITUDE: amplitude_level_r <= pbus.rd_data;
        voice_pkg::OFS_BALANCE: lr_balance_gain_r <= pbus.rd_data;
        voice_pkg::OFS_PITCH_LO: pitch_lo_r <= pbus.rd_data;
        voice_pkg::OFS_PITCH_HI: pitch_hi_r <= pbus.rd_data;
        voice_pkg::OFS_LOOP_LO: loop_origin_low_r <= pbus.rd_data;
        voice_pkg::OFS_LOOP_HI: loop_origin_high_r <= pbus.rd_data;
        voice_pkg::OFS_BEGIN: begin_address_r <= pbus.rd_data;
        default: amplitude_level_r <= amplitude_level_r;
      endcase
    end
  end

  // Waveform data from pins: three stages, accepted when stages two and three agree
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wave_s1_r <= 8'h00;
      wave_s2_r <= 8'h00;
      wave_s3_r <= 8'h00;
      wave_q_r <= 8'h00;
    end else begin
      wave_s1_r <= wave_data_i;
      wave_s2_r <= wave_s1_r;
      wave_s3_r <= wave_s2_r;
      if (wave_s2_r == wave_s3_r) begin
        wave_q_r <= wave_s3_r;
      end
    end
  end

  // Per-channel pointers and sounding history
  genvar g;
  generate
    for (g = 0; g < voice_pkg::N_CHAN; g++) begin : g_chan
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          ptr_r[g] <= '0;
          was_on_r[g] <= 1'b0;
        end else if (chan_r == 3'(g)) begin
          if (slot_r == voice_pkg::SLOT_FETCH) begin
            was_on_r[g] <= sounding;
            if (!sounding || !was_on_r[g]) begin
              ptr_r[g] <= {begin_address_r, 8'h00, {voice_pkg::FRAC_BITS{1'b0}}};
            end else begin
              ptr_r[g] <= ptr_r[g] + PW'(pitch_inc);
            end
          end else if (slot_r == voice_pkg::SLOT_SAMPLE && sounding && wave_q_r == voice_pkg::LOOP_MARK) begin
            ptr_r[g] <= {loop_origin_high_r, loop_origin_low_r, {voice_pkg::FRAC_BITS{1'b0}}};
          end
        end
      end
    end
  endgenerate

  // External memory request: address from the integer part of the pointer
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wave_rd_r <= 1'b0;
    end else begin
      wave_rd_r <= (phase_r == voice_pkg::PH_FETCH) || (phase_r == voice_pkg::PH_REFETCH);
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wave_addr_r <= 16'h0000;
    end else begin
      wave_addr_r <= ptr_r[chan_r][PW-1:voice_pkg::FRAC_BITS];
    end
  end

  // Captured byte: the loop mark is refetched once and never played
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byte_r <= voice_pkg::WAVE_CENTER;
      byte_ok_r <= 1'b0;
    end else if (slot_r == voice_pkg::SLOT_SAMPLE || (slot_r == voice_pkg::SLOT_RESAMPLE && !byte_ok_r)) begin
      byte_r <= wave_q_r;
      byte_ok_r <= wave_q_r != voice_pkg::LOOP_MARK;
    end
  end

  // Gain stage: centred byte times amplitude times balance nibble per side
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      left_part_r <= '0;
      right_part_r <= '0;
    end else if (slot_r == voice_pkg::SLOT_MIX) begin
      logic signed [8:0] centred;
      logic signed [17:0] scaled;
      centred = $signed({1'b0, byte_r}) - $signed({1'b0, voice_pkg::WAVE_CENTER});
      scaled = 18'(centred) * 18'($signed({1'b0, amplitude_level_r}));
      left_part_r <= (21'(scaled) * 21'($signed({1'b0, lr_balance_gain_r[3:0]}))) >>> voice_pkg::MIX_SHIFT;
      right_part_r <= (21'(scaled) * 21'($signed({1'b0, lr_balance_gain_r[7:4]}))) >>> voice_pkg::MIX_SHIFT;
    end
  end

  // Accumulation with limiting; outputs and strobes once per period
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_l_r <= '0;
      acc_r_r <= '0;
    end else if (cnt_r == voice_pkg::CNT_LAST) begin
      acc_l_r <= '0;
      acc_r_r <= '0;
    end else if (slot_r == voice_pkg::SLOT_ACCUM && sounding && byte_ok_r) begin
      acc_l_r <= sat_add(acc_l_r, left_part_r);
      acc_r_r <= sat_add(acc_r_r, right_part_r);
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      left_sample_o <= voice_pkg::OUT_RST;
      right_sample_o <= voice_pkg::OUT_RST;
      hold_r <= 1'b0;
    end else begin
      hold_r <= cnt_r == voice_pkg::CNT_LAST;
      if (cnt_r == voice_pkg::CNT_LAST) begin
        left_sample_o <= {~acc_l_r[15], acc_l_r[14:0]};
        right_sample_o <= {~acc_r_r[15], acc_r_r[14:0]};
      end
    end
  end

  assign wave_addr_o = wave_addr_r;
  assign wave_rd_o = wave_rd_r;
  assign left_hold_pulse_o = hold_r;
  assign right_hold_pulse_o = hold_r;

  // Cycles since the last hold strobe, watched by the period check
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      since_hold_r <= 9'h000;
    end else if (hold_r) begin
      since_hold_r <= 9'h001;
    end else begin
      since_hold_r <= since_hold_r + 9'h001;
    end
  end

  period_len_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (hold_r || since_hold_r == 9'(voice_pkg::CYCLES_PER_SAMPLE))
    |-> (hold_r && since_hold_r == 9'(voice_pkg::CYCLES_PER_SAMPLE))) else $error("hold strobe spacing wrong");
  hold_pair_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hold_r |-> (cnt_r == 9'h000) && $past(chan_r) == 3'h7) else $error("hold strobe not after last channel");
  sample_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !hold_r |-> $stable(left_sample_o) && $stable(right_sample_o))
    else $error("samples changed without strobe");
  chan_order_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_LAST) |=> (chan_r == $past(chan_r) + 3'h1) && slot_r == 6'h00)
    else $error("channel order broken");
  silent_sum_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_ACCUM && !sounding && cnt_r != voice_pkg::CNT_LAST)
    |=> $stable(acc_l_r) && $stable(acc_r_r)) else $error("silent channel changed sum");
  clamp_high_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_ACCUM && sounding && byte_ok_r && left_part_r > 0 && acc_l_r >= 0)
    |=> acc_l_r >= 0) else $error("left sum wrapped negative");
  clamp_low_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_ACCUM && sounding && byte_ok_r && right_part_r < 0 && acc_r_r < 0)
    |=> acc_r_r < 0) else $error("right sum wrapped positive");
  silent_ptr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_FETCH && !sounding) |=> ##1 wave_addr_r == {begin_address_r, 8'h00})
    else $error("silent pointer not at begin address");
  begin_fetch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_FETCH && sounding && !was_on_r[chan_r])
    |=> ##1 wave_addr_r == {begin_address_r, 8'h00} && wave_rd_r) else $error("first fetch not at begin address");
  pitch_step_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_FETCH && sounding && was_on_r[chan_r])
    |=> ptr_r[chan_r] == $past(ptr_r[chan_r]) + PW'(pitch_inc)) else $error("pointer did not step by pitch");
  loop_reload_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_SAMPLE && sounding && wave_q_r == voice_pkg::LOOP_MARK)
    |=> ##1 wave_addr_r == {loop_origin_high_r, loop_origin_low_r} && wave_rd_r) else $error("loop reload missed");
  mark_silent_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_MIX) |-> !(byte_ok_r && byte_r == voice_pkg::LOOP_MARK))
    else $error("loop mark played");
  run_stop_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (slot_r == voice_pkg::SLOT_FETCH && !sound_run_i) |=> !was_on_r[$past(chan_r)]) else $error("run bit ignored");
endmodule : voice_engine
`default_nettype wire

// ### tb/wave_mem_model.sv
// Waveform memory model with a fixed read latency
`timescale 1ns/1ps
`default_nettype none
module wave_mem_model #(
  parameter int LAT = 3
) (
  input wire logic sys_clk_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] pipe_r [0:LAT-1];
  // Without a read the data lines toggle, so a stale byte is never seen
  always @(posedge sys_clk_i) begin
    pipe_r[0] <= rd_i ? mem[addr_i] : ~pipe_r[0];
    for (int i = 1; i < LAT; i++) begin
      pipe_r[i] <= pipe_r[i-1];
    end
  end
  assign data_o = pipe_r[LAT-1];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h80;
    end
    for (int i = 0; i < LAT; i++) begin
      pipe_r[i] = 8'h5a;
    end
  end
endmodule : wave_mem_model
`default_nettype wire

// ### tb/pcm_wavetable_voice_engine_test.sv
// Self-checking bench for the voice engine
`timescale 1ns/1ps
`default_nettype none
module pcm_wavetable_voice_engine_test;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sound_run_i = 1'b0;
  logic [7:0] channel_on_i = 8'h00;
  logic param_wr_i = 1'b0;
  logic [2:0] param_chan_i = 3'h0;
  logic [2:0] param_sel_i = 3'h0;
  logic [7:0] param_data_i = 8'h00;
  logic [15:0] wave_addr_o;
  logic wave_rd_o;
  logic [7:0] wave_data_i;
  logic [15:0] left_sample_o;
  logic [15:0] right_sample_o;
  logic left_hold_pulse_o;
  logic right_hold_pulse_o;
  int err_total = 0;
  int compares = 0;
  int gap;
  logic [7:0] amp_a [8];
  logic [7:0] bal_a [8];
  logic [7:0] byte_a [8];
  logic [7:0] seq_q [$];

  always #5 sys_clk_i = ~sys_clk_i;

  voice_engine uut (.sys_clk_i, .sys_rst_i, .sound_run_i, .channel_on_i, .param_wr_i, .param_chan_i,
    .param_sel_i, .param_data_i, .wave_addr_o, .wave_rd_o, .wave_data_i, .left_sample_o,
    .right_sample_o, .left_hold_pulse_o, .right_hold_pulse_o);
  wave_mem_model #(.LAT(3)) mdl (.sys_clk_i(sys_clk_i), .addr_i(wave_addr_o), .rd_i(wave_rd_o),
    .data_o(wave_data_i));

  task automatic stop_test;
    $display("mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Writes stay back to back; the strobe is dropped once the bank is done
  task automatic wr(input int c, input logic [2:0] sel, input logic [7:0] d);
    param_wr_i = 1'b1;
    param_chan_i = c[2:0];
    param_sel_i = sel;
    param_data_i = d;
    @(posedge sys_clk_i);
    #1;
  endtask : wr

  task automatic cfg(input int c, input logic [7:0] amp, input logic [7:0] bal, input logic [15:0] pitch,
                     input logic [15:0] loop_a, input logic [7:0] beg);
    amp_a[c] = amp;
    bal_a[c] = bal;
    wr(c, voice_pkg::OFS_AMPLITUDE, amp);
    wr(c, voice_pkg::OFS_BALANCE, bal);
    wr(c, voice_pkg::OFS_PITCH_LO, pitch[7:0]);
    wr(c, voice_pkg::OFS_PITCH_HI, pitch[15:8]);
    wr(c, voice_pkg::OFS_LOOP_LO, loop_a[7:0]);
    wr(c, voice_pkg::OFS_LOOP_HI, loop_a[15:8]);
    wr(c, voice_pkg::OFS_BEGIN, beg);
    param_wr_i = 1'b0;
  endtask : cfg

  task automatic wait_pulse;
    gap = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      gap++;
    end while (left_hold_pulse_o !== 1'b1 && gap < 400);
    if (gap >= 400) begin
      err_total++;
      $display("wrong value at %0t: no hold pulse", $time);
      stop_test();
    end
  endtask : wait_pulse

  // Expected output: channels summed in order, clamped after each add
  function automatic logic [15:0] mix(input logic [7:0] on, input bit right);
    int s;
    int t;
    s = 0;
    for (int c = 0; c < 8; c++) begin
      if (on[c]) begin
        t = (int'(byte_a[c]) - 128) * int'(amp_a[c]) * int'(right ? bal_a[c][7:4] : bal_a[c][3:0]);
        s += t >>> 3;
        s = (s > 32767) ? 32767 : ((s < -32768) ? -32768 : s);
      end
    end
    return s[15:0] ^ 16'h8000;
  endfunction : mix

  task automatic chk_out(input logic [7:0] on, input string what);
    chk(left_sample_o, mix(on, 1'b0), what);
    chk(right_sample_o, mix(on, 1'b1), what);
    chk(right_hold_pulse_o, 16'h0001, "right pulse");
  endtask : chk_out

  initial begin
    repeat (20) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    chk(left_sample_o, 16'h8000, "reset left");
    chk(right_sample_o, 16'h8000, "reset right");
    for (int c = 0; c < 8; c++) begin
      cfg(c, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'h00);
    end
    cfg(0, 8'h10, 8'h32, 16'h0400, 16'h1000, 8'h10);
    mdl.mem[16'h1000] = 8'h88;
    mdl.mem[16'h1001] = 8'h90;
    mdl.mem[16'h1002] = 8'h98;
    sound_run_i = 1'b1;
    wait_pulse();
    wait_pulse();
    repeat (15) @(posedge sys_clk_i);
    #1;
    chk(wave_addr_o, 16'h1000, "silent pointer");
    chk(wave_rd_o, 16'h0001, "read strobe");
    wait_pulse();
    channel_on_i = 8'h01;
    seq_q = '{8'h88, 8'h88, 8'h90, 8'h90, 8'h98};
    foreach (seq_q[k]) begin
      wait_pulse();
      byte_a[0] = seq_q[k];
      chk_out(8'h01, "half step");
    end
    $display("test pitch done");
    channel_on_i = 8'h00;
    cfg(1, 8'h20, 8'h11, 16'h0800, 16'h1fff, 8'h20);
    mdl.mem[16'h2000] = 8'ha0;
    mdl.mem[16'h2001] = 8'hff;
    mdl.mem[16'h1fff] = 8'h70;
    wait_pulse();
    wait_pulse();
    channel_on_i = 8'h02;
    for (int k = 0; k < 4; k++) begin
      wait_pulse();
      byte_a[1] = k[0] ? 8'h70 : 8'ha0;
      chk_out(8'h02, "loop");
    end
    // A loop origin that holds the mark again leaves the channel silent for that period
    mdl.mem[16'h1fff] = 8'hff;
    wait_pulse();
    wait_pulse();
    chk_out(8'h00, "double mark");
    $display("test loop done");
    channel_on_i = 8'h00;
    for (int c = 0; c < 7; c++) begin
      cfg(c, 8'hff, 8'hff, 16'h0000, 16'h0000, 8'h30);
      byte_a[c] = 8'hfe;
    end
    cfg(7, 8'h40, 8'h0f, 16'h0000, 16'h0000, 8'h31);
    byte_a[7] = 8'h00;
    mdl.mem[16'h3000] = 8'hfe;
    mdl.mem[16'h3100] = 8'h00;
    wait_pulse();
    channel_on_i = 8'hff;
    wait_pulse();
    chk_out(8'hff, "high clamp");
    mdl.mem[16'h3000] = 8'h00;
    for (int c = 0; c < 7; c++) begin
      byte_a[c] = 8'h00;
    end
    wait_pulse();
    chk_out(8'hff, "low clamp");
    $display("test clamp done");
    sound_run_i = 1'b0;
    wait_pulse();
    wait_pulse();
    chk(gap[15:0], 16'h0180, "period");
    chk_out(8'h00, "run off");
    $display("test run bit done");
    stop_test();
  end
endmodule : pcm_wavetable_voice_engine_test
`default_nettype wire
